// file: core/pcl_device.sv
`timescale 1ns/1ps
// Functional notes
// - Parallel strobe rise captures loop and output dividers.
// - Parallel strobe low: divider latches follow inputs.
// - Serial clock shifts data into 14-bit register.
// - Serial loading only while parallel strobe high.
// - Frame order: test, output divider, loop divider.
// - Each field sent most significant bit first.
// - Serial strobe fall transfers shifted values.
// - Serial strobe high: latches follow shift register.
// - Serial data sampled on serial clock rise.
// - Test select settable only through serial stream.
// - Parallel strobe low forces test select zero.
// - Test select code chooses observation output source.
// - Code 110 bypasses PLL with serial clock.
// - Bypass output at most half serial clock rate.
// - Bypass loop counter output may be asymmetric.
// - Parallel strobe low resets observation latch.
// - Host changes frequency in smallest steps; pcl_host loads each requested divider value in one load.
// - Output select maps to divide 2,4,8,16.
// - Output enable applied synchronously, no runt pulses.
module pcl_device import pcl_pkg::*; #(
	parameter int SHIFT_LEN = SR_W
) (
	input wire logic CLK,
	input wire logic RST,
	pcl_if.device PINS,
	input wire logic VCO_TICK,
	input wire logic REF_TICK,
	output wire logic SYNTH_OUT,
	output logic TEST_OUT,
	output logic [M_W-1:0] M_CFG,
	output logic [N_W-1:0] N_CFG,
	output logic [T_W-1:0] T_CFG
);
	// The fields are cut out of the frame by position, so the frame must hold exactly them.
	if (SHIFT_LEN != M_W + N_W + T_W) begin : g_len_check
		$error("Shift length must equal the sum of the three field widths.");
	end
	if (M_LSB + M_W != N_LSB || N_LSB + N_W != T_LSB
			|| T_LSB + T_W != SHIFT_LEN) begin : g_pos_check
		$error("Field positions must tile the shift register without gaps.");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin edge detection.
	// The pins are levels taken as synchronous to CLK, so each edge is found in the cycle the pin first shows it
	// by comparing with last cycle's copy. The copies reset low, the level the host drives on these three pins
	// in reset, so no false edge follows reset.

	logic p_load_q;
	logic s_clock_q;
	logic s_load_q;
	logic [SHIFT_LEN-1:0] sr_r;

	wire parallel_load_strobe_low = ~PINS.parallel_load;
	wire p_rise = PINS.parallel_load & ~p_load_q;
	wire sclk_rise = PINS.s_clock & ~s_clock_q;
	// Only the falling edge of the serial strobe is needed: it closes the serial path.
	wire s_fall = ~PINS.s_load & s_load_q;
	// Data is taken at serial clock rises only. While the parallel strobe is low nothing
	// shifts, so the leading bit of the last frame stays in the top position.
	wire shift_en = sclk_rise & PINS.parallel_load;
	wire [SHIFT_LEN-1:0] sr_nxt = shift_en ? {sr_r[SHIFT_LEN-2:0], PINS.s_data} : sr_r;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			p_load_q <= 1'b0;
			s_clock_q <= 1'b0;
			s_load_q <= 1'b0;
			sr_r <= '0;
		end else begin
			p_load_q <= PINS.parallel_load;
			s_clock_q <= PINS.s_clock;
			s_load_q <= PINS.s_load;
			sr_r <= sr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration latches. The parallel path has priority over the serial one.

	logic [M_W-1:0] m_nxt;
	logic [N_W-1:0] n_nxt;
	logic [T_W-1:0] t_nxt;

	wire [M_W-1:0] sr_m = sr_r[M_LSB +: M_W];
	wire [N_W-1:0] sr_n = sr_r[N_LSB +: N_W];
	wire [T_W-1:0] sr_t = sr_r[T_LSB +: T_W];
	// The latches are modelled as flops that follow their source every cycle while open, so
	// the configuration lags the pins by one cycle. Each path stays open for the cycle in
	// which its strobe edge is seen, so the value standing at that edge is the one kept.
	wire par_open = parallel_load_strobe_low | p_rise;
	wire ser_open = PINS.parallel_load & (PINS.s_load | s_fall);

	always_comb begin
		m_nxt = M_CFG;
		n_nxt = N_CFG;
		t_nxt = T_CFG;
		if (par_open) begin
			m_nxt = PINS.m_div;
			n_nxt = PINS.n_div;
			t_nxt = T_RST;
		end else if (ser_open) begin
			m_nxt = sr_m;
			n_nxt = sr_n;
			t_nxt = sr_t;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			// Reset values follow the pulled-up parallel pins and the quiet test selection.
			M_CFG <= M_RST;
			N_CFG <= N_RST;
			T_CFG <= T_RST;
		end else begin
			M_CFG <= m_nxt;
			N_CFG <= n_nxt;
			T_CFG <= t_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Divider chain. In bypass the serial clock rises replace the VCO ticks.

	logic [M_W-1:0] loop_cnt_r;
	logic loop_out_r;
	logic synth_q;
	logic [1:0] div4_r;

	wire bypass = (pcl_test_e'(T_CFG) == TS_BYPASS);
	// In bypass the serial clock rises stand in for the oscillator, so a board can step
	// the whole divider chain by hand.
	wire src_tick = bypass ? sclk_rise : VCO_TICK;
	// A loop divider of zero is taken as a wrap on every tick, so the counter never runs
	// past its modulus when the subtraction below would underflow.
	wire m_zero = (M_CFG == '0);
	wire loop_wrap = m_zero | (loop_cnt_r >= M_CFG - 9'h001);
	wire synth_rise = SYNTH_OUT & ~synth_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			loop_cnt_r <= '0;
			loop_out_r <= 1'b0;
			synth_q <= 1'b0;
			div4_r <= 2'h0;
		end else begin
			// The loop flag is high for one source tick per wrap, so its duty cycle is not
			// symmetric; only the output divider gives a symmetric output.
			if (src_tick) begin
				loop_cnt_r <= loop_wrap ? '0 : loop_cnt_r + 9'h001;
				loop_out_r <= loop_wrap;
			end
			// The divide-by-four view counts rising edges of the divided output.
			synth_q <= SYNTH_OUT;
			if (synth_rise) begin
				div4_r <= div4_r + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output divider.

	// The output toggles at most once per source tick, so its period is at least two
	// ticks and in bypass it runs at no more than half the serial clock rate.
	pcl_out_div u_out_div (
		.clk(CLK),
		.rst(RST),
		.tick(src_tick),
		.n_sel(N_CFG),
		.oe(PINS.oe),
		.out(SYNTH_OUT)
	);

	////////////////////////////////////////////////////////////////////////////
	// Observation output. Codes 011 and 110 both show the loop flag; in 110 it is
	// counted from serial clock rises. While the parallel strobe is low the output latch
	// is held in reset and shows the leading bit of the shift register instead.

	logic test_sel;

	always_comb begin
		unique case (pcl_test_e'(T_CFG))
			TS_SHIFT: test_sel = sr_r[SHIFT_LEN-1];
			TS_HIGH: test_sel = 1'b1;
			TS_REF: test_sel = REF_TICK;
			TS_LOOP: test_sel = loop_out_r;
			TS_SYNTH: test_sel = SYNTH_OUT;
			TS_LOW: test_sel = 1'b0;
			TS_BYPASS: test_sel = loop_out_r;
			TS_DIV4: test_sel = div4_r[1];
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			TEST_OUT <= 1'b0;
		end else if (parallel_load_strobe_low) begin
			TEST_OUT <= sr_r[SHIFT_LEN-1];
		end else begin
			TEST_OUT <= test_sel;
		end
	end
endmodule : pcl_device

// file: core/pcl_pkg.sv
package pcl_pkg;
	localparam int M_W = 9;
	localparam int N_W = 2;
	localparam int T_W = 3;
	localparam int SR_W = 14;
	// Field positions inside the serial frame, first-shifted field on top.
	localparam int M_LSB = 0;
	localparam int N_LSB = 9;
	localparam int T_LSB = 11;
	// Reset values follow the pulled-up parallel pins and the quiet test selection.
	localparam logic [M_W-1:0] M_RST = 9'h1ff;
	localparam logic [N_W-1:0] N_RST = 2'h3;
	localparam logic [T_W-1:0] T_RST = 3'h0;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCLK_HALF_NS = 50;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_PW_NS = 50;
	localparam int LOAD_PW_CYC = (LOAD_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 8;

	typedef enum logic [T_W-1:0] {
		TS_SHIFT, TS_HIGH, TS_REF, TS_LOOP, TS_SYNTH, TS_LOW, TS_BYPASS, TS_DIV4
	} pcl_test_e;

	// Source ticks per half period of the output divider: 1, 2, 4, 8, for ratio 2, 4, 8, 16.
	function automatic logic [3:0] pcl_half_ratio(input logic [N_W-1:0] n);
		pcl_half_ratio = 4'h1 << n;
	endfunction : pcl_half_ratio
endpackage : pcl_pkg

// file: core/pcl_if.sv
`timescale 1ns/1ps
interface pcl_if;
	import pcl_pkg::*;
	logic parallel_load;
	logic [M_W-1:0] m_div;
	logic [N_W-1:0] n_div;
	logic s_clock;
	logic s_data;
	logic s_load;
	logic oe;

	modport device (input parallel_load, m_div, n_div, s_clock, s_data, s_load, oe);
	modport host (output parallel_load, m_div, n_div, s_clock, s_data, s_load, oe);
endinterface : pcl_if

// file: core/pcl_out_div.sv
`timescale 1ns/1ps
module pcl_out_div import pcl_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [N_W-1:0] n_sel,
	input wire logic oe,
	output logic out
);
	logic [3:0] cnt_r;
	logic phase_r;
	logic en_r;
	wire [3:0] half = pcl_half_ratio(n_sel);
	wire flip = tick && (cnt_r >= half - 4'h1);
	wire phase_nxt = flip ? ~phase_r : phase_r;
	// Enable only changes where a high phase would start, so no pulse is cut short.
	wire en_nxt = (flip && !phase_r) ? oe : en_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			phase_r <= 1'b0;
			en_r <= 1'b0;
			out <= 1'b0;
		end else begin
			if (tick) begin
				cnt_r <= flip ? 4'h0 : cnt_r + 4'h1;
			end
			phase_r <= phase_nxt;
			en_r <= en_nxt;
			out <= phase_nxt & en_nxt;
		end
	end
endmodule : pcl_out_div

// file: core/pcl_host.sv
`timescale 1ns/1ps
module pcl_host import pcl_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	pcl_if.host PINS,
	input wire logic PAR_REQ,
	input wire logic [M_W-1:0] PAR_M,
	input wire logic [N_W-1:0] PAR_N,
	input wire logic SER_REQ,
	input wire logic [T_W-1:0] SER_T,
	input wire logic [N_W-1:0] SER_N,
	input wire logic [M_W-1:0] SER_M,
	input wire logic OE_IN,
	output logic BUSY,
	output logic DONE
);
	typedef enum logic [2:0] {H_IDLE, H_PLOW, H_BIT_LO, H_BIT_HI, H_SLOAD} pcl_host_e;

	pcl_host_e st_r;
	logic [TMR_W-1:0] tmr_r;
	logic [3:0] bit_r;
	logic [SR_W-1:0] frame_r;
	logic p_load_r;
	logic [M_W-1:0] m_r;
	logic [N_W-1:0] n_r;
	logic s_clock_r;
	logic s_load_r;
	logic oe_r;

	wire tmr_done = (tmr_r == '0);
	wire take_par = (st_r == H_IDLE) && PAR_REQ;
	// A serial frame only works with the parallel strobe high.
	wire take_ser = (st_r == H_IDLE) && !PAR_REQ && SER_REQ && p_load_r;
	wire last_bit = (bit_r == 4'(SR_W - 1));

	assign PINS.parallel_load = p_load_r;
	assign PINS.m_div = m_r;
	assign PINS.n_div = n_r;
	assign PINS.s_clock = s_clock_r;
	assign PINS.s_data = frame_r[SR_W-1];
	assign PINS.s_load = s_load_r;
	assign PINS.oe = oe_r;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r <= H_IDLE;
			tmr_r <= '0;
			bit_r <= 4'h0;
			frame_r <= '0;
			p_load_r <= 1'b0;
			m_r <= M_RST;
			n_r <= N_RST;
			s_clock_r <= 1'b0;
			s_load_r <= 1'b0;
			oe_r <= 1'b0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end else begin
			oe_r <= OE_IN;
			DONE <= 1'b0;
			if (!tmr_done) begin
				tmr_r <= tmr_r - 8'h01;
			end
			unique case (st_r)
				H_IDLE: begin
					if (take_par) begin
						m_r <= PAR_M;
						n_r <= PAR_N;
						p_load_r <= 1'b0;
						tmr_r <= TMR_W'(LOAD_PW_CYC - 1);
						BUSY <= 1'b1;
						st_r <= H_PLOW;
					end else if (take_ser) begin
						frame_r <= {SER_T, SER_N, SER_M};
						bit_r <= 4'h0;
						tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
						BUSY <= 1'b1;
						st_r <= H_BIT_LO;
					end
				end
				H_PLOW: begin
					if (tmr_done) begin
						p_load_r <= 1'b1;
						BUSY <= 1'b0;
						DONE <= 1'b1;
						st_r <= H_IDLE;
					end
				end
				H_BIT_LO: begin
					if (tmr_done) begin
						s_clock_r <= 1'b1;
						tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
						st_r <= H_BIT_HI;
					end
				end
				H_BIT_HI: begin
					if (tmr_done) begin
						s_clock_r <= 1'b0;
						tmr_r <= TMR_W'(SCLK_HALF_CYC - 1);
						if (last_bit) begin
							s_load_r <= 1'b1;
							st_r <= H_SLOAD;
						end else begin
							frame_r <= {frame_r[SR_W-2:0], 1'b0};
							bit_r <= bit_r + 4'h1;
							st_r <= H_BIT_LO;
						end
					end
				end
				H_SLOAD: begin
					if (tmr_done) begin
						s_load_r <= 1'b0;
						BUSY <= 1'b0;
						DONE <= 1'b1;
						st_r <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule : pcl_host

// file: test/pcl_chk.sv
`timescale 1ns/1ps
module pcl_chk import pcl_pkg::*; (
	input logic CLK,
	input logic RST,
	input logic parallel_load,
	input logic [M_W-1:0] m_div,
	input logic [N_W-1:0] n_div,
	input logic s_clock,
	input logic s_data,
	input logic s_load,
	input logic [M_W-1:0] M_CFG,
	input logic [N_W-1:0] N_CFG,
	input logic [T_W-1:0] T_CFG
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence sload_hi;
		s_load [*8];
	endsequence
	a_par_follow: assert property (
		!parallel_load |=> M_CFG == $past(m_div) && N_CFG == $past(n_div))
		else $error("config not following parallel pins");
	a_par_capture: assert property (
		$rose(parallel_load) |=> M_CFG == $past(m_div, 2))
		else $error("parallel capture wrong");
	a_test_zero: assert property (!parallel_load |=> T_CFG == 3'h0)
		else $error("test select not zero");
	a_cfg_hold: assert property (
		parallel_load && $past(parallel_load) && !s_load && !$past(s_load)
		|=> $stable({M_CFG, N_CFG, T_CFG}))
		else $error("config changed without load");
	a_t_serial: assert property (
		$changed(T_CFG) && T_CFG != 3'h0 |-> $past(s_load) || $past(s_load, 2))
		else $error("test select set without serial load");
	a_ser_pl: assert property (s_clock || s_load |-> parallel_load)
		else $error("serial activity with parallel strobe low");
	a_data_hold: assert property (s_clock |-> $stable(s_data))
		else $error("serial data moved in clock high");
	a_sclk_half: assert property ($rose(s_clock) |-> s_clock [*8])
		else $error("serial clock too fast");
	a_sload_pulse: assert property ($rose(s_load) |-> sload_hi ##3 !s_load)
		else $error("serial strobe width wrong");
endmodule : pcl_chk

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pcl_pkg::*;
	logic clk, rst, par_req, ser_req, oe_in, vco_tick, ref_tick;
	logic synth_out, test_out, busy, done;
	logic [M_W-1:0] par_m, ser_m, m_cfg;
	logic [N_W-1:0] par_n, ser_n, n_cfg;
	logic [T_W-1:0] ser_t, t_cfg;
	int fail_count, total_checks, tog;
	logic sr_top;
	pcl_if pins();
	pcl_host u_pcl_host (.CLK(clk), .RST(rst), .PINS(pins), .PAR_REQ(par_req),
		.PAR_M(par_m), .PAR_N(par_n), .SER_REQ(ser_req), .SER_T(ser_t), .SER_N(ser_n),
		.SER_M(ser_m), .OE_IN(oe_in), .BUSY(busy), .DONE(done));
	pcl_device u_pcl_device (.CLK(clk), .RST(rst), .PINS(pins), .VCO_TICK(vco_tick),
		.REF_TICK(ref_tick), .SYNTH_OUT(synth_out), .TEST_OUT(test_out),
		.M_CFG(m_cfg), .N_CFG(n_cfg), .T_CFG(t_cfg));
	pcl_chk u_pcl_chk (.CLK(clk), .RST(rst), .parallel_load(pins.parallel_load),
		.m_div(pins.m_div), .n_div(pins.n_div), .s_clock(pins.s_clock),
		.s_data(pins.s_data), .s_load(pins.s_load), .M_CFG(m_cfg), .N_CFG(n_cfg),
		.T_CFG(t_cfg));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(synth_out) tog++;
	task chk(input string nm, input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// One parallel (p=1) or serial load, then a check of the loaded configuration.
	task go(input logic p, input logic [2:0] t, input logic [1:0] n, input logic [8:0] m);
		int i;
		@(negedge clk);
		{par_req, ser_req} = {p, !p};
		{par_m, par_n, ser_t, ser_n, ser_m} = {m, n, t, n, m};
		@(negedge clk);
		{par_req, ser_req} = 2'b00;
		tog = 0;
		if (p) begin
			@(negedge clk);
			chk("obs", 14'(test_out), 14'(sr_top));
			chk("test low", 14'(t_cfg), 14'h0);
		end
		for (i = 0; i < 400 && done !== 1'b1; i++)
			@(negedge clk);
		repeat (3) @(negedge clk);
		chk("done", 14'(i < 400), 14'h1);
		chk("cfg", {t_cfg, n_cfg, m_cfg}, {p ? 3'h0 : t, n, m});
		if (!p)
			sr_top = t[2];
	endtask : go
	task t_codes;
		for (int c = 0; c < 8; c++) begin
			go(1'b0, 3'(c), 2'(c), 9'h0f0 + 9'(c));
			if (c == 1 || c == 5)
				chk("test", 14'(test_out), 14'(c == 1));
			if (c == 2) begin
				ref_tick = 1'b1;
				repeat (2) @(negedge clk);
				chk("ref", 14'(test_out), 14'h1);
				ref_tick = 1'b0;
				repeat (2) @(negedge clk);
				chk("ref", 14'(test_out), 14'h0);
			end
		end
		$display("codes done");
	endtask : t_codes
	task t_bypass;
		go(1'b0, 3'h6, 2'h0, 9'h005);
		go(1'b0, 3'h6, 2'h0, 9'h005);
		chk("bypass", 14'(tog), 14'd14);
		go(1'b1, 3'h0, 2'h2, 9'h106);
		$display("bypass done");
	endtask : t_bypass
	task t_vco;
		logic hi0;
		for (int k = 0; k < 2; k++) begin
			hi0 = synth_out;
			tog = 0;
			repeat (32) begin
				@(negedge clk);
				vco_tick = 1'b1;
				@(negedge clk);
				vco_tick = 1'b0;
			end
			// With the enable low, a high pulse already begun still ends in full.
			chk("toggles", 14'(tog), k ? 14'(hi0) : 14'd8);
			if (k)
				chk("oe off", 14'(synth_out), 14'h0);
			oe_in = 1'b0;
			repeat (3) @(negedge clk);
		end
		$display("vco done");
	endtask : t_vco
	initial begin
		{rst, par_req, ser_req, vco_tick, ref_tick, oe_in} = 6'b100001;
		{par_m, par_n, ser_t, ser_n, ser_m} = '0;
		sr_top = 1'b0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		go(1'b1, 3'h0, 2'h1, 9'h106);
		t_codes;
		t_bypass;
		t_vco;
		finish_test;
	end
	initial begin
		#100000;
		fail_count++;
		finish_test;
	end
endmodule : testbench
